/* File: inc/lhp_regs.svh */
// Constants of the LCD host parallel port
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH

// Interface mode straps (mode bits 1..0)
`define LHP_IM_W8 2'h0
`define LHP_IM_W16 2'h1
`define LHP_IM_W9 2'h2
`define LHP_IM_W18 2'h3

// Bus width of the data lines and of commands
`define LHP_BUS_W 18
`define LHP_CMD_W 8

// Lane masks per selected width
`define LHP_MASK_W8 18'h000ff
`define LHP_MASK_W9 18'h001ff
`define LHP_MASK_W16 18'h0ffff
`define LHP_MASK_W18 18'h3ffff

// Parameter index field
`define LHP_PIDX_W 8
`define LHP_PIDX_MAX 8'hff

// Reset values
`define LHP_DOUT_RST 18'h00000
`define LHP_PIDX_RST 8'h00

// Buffer shape
`define LHP_FIFO_DEPTH 32

`endif

/* File: inc/lhp_pkg.sv */
// Types of the LCD host parallel port
`default_nettype none
package lhp_pkg;

  typedef enum logic [4:0] {
    LHP_SERIAL = 5'b00001,
    LHP_PAR8 = 5'b00010,
    LHP_PAR16 = 5'b00100,
    LHP_PAR9 = 5'b01000,
    LHP_PAR18 = 5'b10000
  } lhp_mode_e;

  typedef struct packed {
    logic straps_taken;
    logic style_6800;
    lhp_mode_e mode;
    logic wr_prev;
    logic en_prev;
    logic rd_prev;
    logic [7:0] pidx;
    logic [17:0] dout;
    logic oe;
    logic read_req;
    logic read_dc;
    logic overflow;
  } lhp_state_s;

endpackage : lhp_pkg
`default_nettype wire

/* File: rtl/lhp_port.sv */
// Host parallel port of the LCD driver with its write buffer
`timescale 1ns/1ps
`default_nettype none
`include "lhp_regs.svh"

////////////////////////////////////////////////////////////////////////
module lhp_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = `LHP_FIFO_DEPTH
) (
  input wire logic mclk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic flush, // Synchronous clear
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Word out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } lhp_fifo_s;

  lhp_fifo_s s_q;
  lhp_fifo_s s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (s_q.count != DEPTH[AW:0]);
  assign out_valid = (s_q.count != '0);
  assign out_data = mem[s_q.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (pop)
    begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush)
    begin
      s_d = '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Storage has no reset; only valid words are ever read
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[s_q.wptr] <= in_data;
    end
  end

  chk_fifo_count_bound : assert property (@(posedge mclk) disable iff (!resetn)
    s_q.count <= DEPTH[AW:0])
    else $error("fifo count beyond depth");

endmodule : lhp_fifo

////////////////////////////////////////////////////////////////////////
module lhp_port
  import lhp_pkg::*;
(
  input wire logic mclk, // System clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic hw_reset_n, // External hardware reset, active low
  input wire logic bus_style_strap, // 0: 8080, 1: 6800
  input wire logic if_mode_bit2, // 0: serial interface
  input wire logic if_mode_bit1, // Width select high bit
  input wire logic if_mode_bit0, // Width select low bit
  input wire logic chip_select_n, // Chip select, active low
  input wire logic write_strobe_n, // 8080 write; 6800 direction_flag
  input wire logic read_strobe_n, // 8080 read; 6800 enable
  input wire logic cmd_data_flag, // 0 command, 1 data/parameter
  input wire logic [17:0] data_in, // Data lines, input side
  output logic [17:0] data_out, // Data lines, output side
  output logic data_oe, // High while driving data lines
  output logic serial_sel, // Serial interface selected
  output logic style_6800, // 6800 style in use
  output logic [4:0] bus_mode, // One-hot interface mode
  output logic wr_ready, // Buffer has room
  output logic overflow, // Sticky: write lost to full buffer
  output logic word_valid, // Buffered word available
  input wire logic word_ready, // Consumer takes the word
  output logic word_is_data, // Word is data or parameter
  output logic [7:0] word_pidx, // Parameter index of the word
  output logic [17:0] word_data, // Word value
  output logic read_req, // Pulse: read access started
  output logic read_dc, // Flag value of that read
  input wire logic read_ram, // User: read returns display data
  input wire logic [17:0] read_data // User read answer, same cycle
);
  localparam int FW = 1 + `LHP_PIDX_W + `LHP_BUS_W;

  lhp_state_s s_q;
  lhp_state_s s_d;
  logic direction_flag;
  logic enable_strobe;
  logic parallel;
  logic selected;
  logic rd_active;
  logic rd_start;
  logic wr_take;
  logic [17:0] mask;
  logic [17:0] wr_word;
  logic [FW-1:0] fifo_in;
  logic [FW-1:0] fifo_out;
  logic in_ready_w;

  // In 6800 style the two strobe pins change meaning
  assign direction_flag = write_strobe_n;
  assign enable_strobe = read_strobe_n;

  // Parallel port live only when selected
  assign parallel = s_q.straps_taken && (s_q.mode != LHP_SERIAL);
  assign selected = parallel && !chip_select_n;

  function automatic logic [17:0] width_mask(input lhp_mode_e m);
    case (m)
      LHP_PAR8: width_mask = `LHP_MASK_W8;
      LHP_PAR9: width_mask = `LHP_MASK_W9;
      LHP_PAR16: width_mask = `LHP_MASK_W16;
      LHP_PAR18: width_mask = `LHP_MASK_W18;
      default: width_mask = `LHP_MASK_W8;
    endcase
  endfunction : width_mask

  assign mask = width_mask(s_q.mode);

  ////////////////////////////////////////////////////////////////////
  // Access detection. Edges come from the previous sample only, so a
  // stopped strobe simply produces no event.
  // 8080 read spans the low phase of the read strobe
  // 6800 read spans enable high with direction one
  assign rd_active = s_q.style_6800 ?
    (selected && enable_strobe && direction_flag) :
    (selected && !read_strobe_n && write_strobe_n);
  assign rd_start = rd_active && !s_q.rd_prev;

  // 8080 write taken on write strobe rise
  // 6800 write taken on enable fall, direction zero
  // Edges only counted while selected; no strobe timing assumed
  always_comb
  begin
    if (s_q.style_6800)
    begin
      wr_take = selected && s_q.en_prev && !enable_strobe &&
        !direction_flag;
    end
    else
    begin
      wr_take = selected && !s_q.wr_prev && write_strobe_n &&
        read_strobe_n;
    end
  end

  // Commands on the low byte only
  // Data and parameters masked to selected width
  assign wr_word = cmd_data_flag ? (data_in & mask) :
    {10'h000, data_in[`LHP_CMD_W-1:0]};

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.read_req = 1'b0;
    s_d.wr_prev = write_strobe_n;
    s_d.en_prev = enable_strobe;
    s_d.rd_prev = rd_active;
    // Straps caught once after reset release
    if (!s_q.straps_taken)
    begin
      s_d.straps_taken = 1'b1;
      s_d.style_6800 = bus_style_strap;
      if (!if_mode_bit2)
      begin
        s_d.mode = LHP_SERIAL;
      end
      else
      begin
        case ({if_mode_bit1, if_mode_bit0})
          `LHP_IM_W8: s_d.mode = LHP_PAR8;
          `LHP_IM_W16: s_d.mode = LHP_PAR16;
          `LHP_IM_W9: s_d.mode = LHP_PAR9;
          `LHP_IM_W18: s_d.mode = LHP_PAR18;
          default: s_d.mode = LHP_PAR8;
        endcase
      end
    end
    // Command restarts index; parameters kept downstream
    if (wr_take && in_ready_w)
    begin
      if (!cmd_data_flag)
      begin
        s_d.pidx = `LHP_PIDX_RST;
      end
      else if (s_q.pidx != `LHP_PIDX_MAX)
      begin
        s_d.pidx = s_q.pidx + 8'h01;
      end
    end
    // Full buffer: the word is lost and flagged, host cannot wait
    if (wr_take && !in_ready_w)
    begin
      s_d.overflow = 1'b1;
    end
    // Status reads eight bits, display data masked to selected width
    if (rd_start)
    begin
      s_d.read_req = 1'b1;
      s_d.read_dc = cmd_data_flag;
      s_d.dout = read_ram ? (read_data & mask) :
        {10'h000, read_data[`LHP_CMD_W-1:0]};
    end
    // Drive only inside an active read
    s_d.oe = rd_active;
    // Hardware reset clears port and recaptures straps
    if (!hw_reset_n)
    begin
      s_d = '0;
      s_d.mode = LHP_SERIAL;
      s_d.wr_prev = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.mode <= LHP_SERIAL;
      s_q.wr_prev <= 1'b1;
      s_q.dout <= `LHP_DOUT_RST;
      s_q.pidx <= `LHP_PIDX_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign fifo_in = {cmd_data_flag, s_q.pidx, wr_word};

  lhp_fifo #(
    .WIDTH(FW),
    .DEPTH(`LHP_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .flush(!hw_reset_n),
    .in_valid(wr_take),
    .in_ready(in_ready_w),
    .in_data(fifo_in),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(fifo_out)
  );

  assign word_is_data = fifo_out[FW-1];
  assign word_pidx = fifo_out[FW-2 -: `LHP_PIDX_W];
  assign word_data = fifo_out[`LHP_BUS_W-1:0];
  assign wr_ready = in_ready_w;
  assign data_out = s_q.dout;
  assign data_oe = s_q.oe;
  assign serial_sel = (s_q.mode == LHP_SERIAL);
  assign style_6800 = s_q.style_6800;
  assign bus_mode = s_q.mode;
  assign overflow = s_q.overflow;
  assign read_req = s_q.read_req;
  assign read_dc = s_q.read_dc;

  ////////////////////////////////////////////////////////////////////
  chk_serial_no_drive : assert property (@(posedge mclk)
    disable iff (!resetn) serial_sel |-> !data_oe)
    else $error("data driven in serial mode");
  chk_cmd_low_byte : assert property (@(posedge mclk)
    disable iff (!resetn)
    (word_valid && !word_is_data) |-> (word_data[17:8] == 10'h000))
    else $error("command wider than eight bits");
  chk_desel_no_write : assert property (@(posedge mclk)
    disable iff (!resetn) (chip_select_n && !word_valid) |=> !word_valid)
    else $error("write taken while deselected");
  chk_oe_follows_read : assert property (@(posedge mclk)
    disable iff (!resetn) (rd_active && hw_reset_n) |=> data_oe)
    else $error("read active without drive");
  chk_oe_off_desel : assert property (@(posedge mclk)
    disable iff (!resetn) ($past(chip_select_n) && hw_reset_n) |-> !data_oe)
    else $error("drive while deselected");
  chk_8080_write_rise : assert property (@(posedge mclk)
    disable iff (!resetn) (wr_take && !s_q.style_6800) |->
      (!$past(write_strobe_n) && write_strobe_n))
    else $error("8080 write not on rising strobe");
  chk_6800_write_fall : assert property (@(posedge mclk)
    disable iff (!resetn) (wr_take && s_q.style_6800) |->
      ($past(enable_strobe) && !enable_strobe && !direction_flag))
    else $error("6800 write not on falling enable");
  chk_read_width : assert property (@(posedge mclk)
    disable iff (!resetn)
    (rd_start && hw_reset_n && !read_ram) |=> (data_out[17:8] == 10'h000))
    else $error("status read wider than eight bits");
  chk_cmd_clears_pidx : assert property (@(posedge mclk)
    disable iff (!resetn)
    (wr_take && in_ready_w && !cmd_data_flag && hw_reset_n) |=>
      (s_q.pidx == `LHP_PIDX_RST))
    else $error("command did not restart index");
  chk_pidx_held_desel : assert property (@(posedge mclk)
    disable iff (!resetn) (chip_select_n && hw_reset_n) |=> $stable(s_q.pidx))
    else $error("index moved during pause");
  chk_hw_reset_clears : assert property (@(posedge mclk)
    disable iff (!resetn)
    !hw_reset_n |=> (!data_oe && !word_valid && !overflow))
    else $error("hardware reset did not clear port");

endmodule : lhp_port
`default_nettype wire

/* File: tb/lhp_host.sv */
// Host microcontroller model driving the parallel pins
`timescale 1ns/1ps
`default_nettype none
module lhp_host (
  input wire logic mclk, // System clock
  input wire logic style, // 1: 6800 pin use
  output logic cs_n, // Chip select
  output logic wr_n, // Write strobe or direction
  output logic rd_n, // Read strobe or enable
  output logic dc, // Command/data flag
  output logic [17:0] d, // Data lines toward device
  input wire logic [17:0] q // Resolved data wire
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dc = 1'b0;
    d = 18'h00000;
  end

  task gap(input int n);
    repeat (n) @(negedge mclk);
  endtask : gap

  task idle();
    wr_n = ~style;
    rd_n = ~style;
  endtask : idle

  ////////////////////////////////////////////////////////////////////////
  task write(input logic sel, input logic f, input logic [17:0] v);
    @(negedge mclk);
    cs_n = ~sel;
    dc = f;
    d = v;
    if (style)
      rd_n = 1'b1;
    else
      wr_n = 1'b0;
    gap(2);
    idle();
    gap(2);
    cs_n = 1'b1;
    // Released lines must not keep the old value
    d = ~v;
  endtask : write

  task read(input logic f, output logic [17:0] v);
    @(negedge mclk);
    cs_n = 1'b0;
    dc = f;
    // strobe pulse, sample at its end
    if (style)
    begin
      wr_n = 1'b1;
      rd_n = 1'b1;
    end
    else
      rd_n = 1'b0;
    gap(3);
    v = q;
    // Enable falls before direction turns round
    rd_n = ~rd_n;
    gap(1);
    idle();
    gap(1);
    cs_n = 1'b1;
    gap(1);
  endtask : read
endmodule : lhp_host
`default_nettype wire

/* File: tb/lhp_tb.sv */
// Self-checking testbench of the LCD host parallel port
`timescale 1ns/1ps
`default_nettype none
`include "lhp_regs.svh"
module testbench
  import lhp_pkg::*;
;
  logic mclk, resetn, hw_reset_n, strap, cs_n, wr_n, rd_n, dc, oe, ser;
  logic sty, wr_ready, overflow, word_valid, word_ready, word_is_data;
  logic read_req, read_dc, read_ram;
  logic [2:0] im;
  logic [4:0] bus_mode;
  logic [7:0] word_pidx;
  logic [17:0] hd, din, dout, word_data, read_data, v;
  int errors, checks, reads;

  assign din = oe ? dout : hd;

  // Read request stands one cycle, so each negedge sees it once
  always @(negedge mclk)
  begin
    if (read_req === 1'b1)
    begin
      reads++;
    end
  end

  lhp_host host (.mclk(mclk), .style(strap), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .dc(dc), .d(hd), .q(din));

  lhp_port dut (.mclk(mclk), .resetn(resetn), .hw_reset_n(hw_reset_n),
    .bus_style_strap(strap), .if_mode_bit2(im[2]), .if_mode_bit1(im[1]),
    .if_mode_bit0(im[0]), .chip_select_n(cs_n), .write_strobe_n(wr_n),
    .read_strobe_n(rd_n), .cmd_data_flag(dc), .data_in(din),
    .data_out(dout), .data_oe(oe), .serial_sel(ser), .style_6800(sty),
    .bus_mode(bus_mode), .wr_ready(wr_ready), .overflow(overflow),
    .word_valid(word_valid), .word_ready(word_ready),
    .word_is_data(word_is_data), .word_pidx(word_pidx),
    .word_data(word_data), .read_req(read_req), .read_dc(read_dc),
    .read_ram(read_ram), .read_data(read_data));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [26:0] e, input logic [26:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [17:0] mask(input logic [1:0] w);
    case (w)
      2'h0: return `LHP_MASK_W8;
      2'h1: return `LHP_MASK_W16;
      2'h2: return `LHP_MASK_W9;
      default: return `LHP_MASK_W18;
    endcase
  endfunction : mask

  // Straps are caught only after a reset
  task setup(input logic s, input logic [2:0] m);
    @(negedge mclk);
    strap = s;
    im = m;
    hw_reset_n = 1'b0;
    // Idle levels follow the new style only once its pin has settled
    repeat (2) @(negedge mclk);
    host.idle();
    hw_reset_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask : setup

  task pop(input logic f, input logic [7:0] p, input logic [17:0] d);
    int i;
    i = 0;
    while (word_valid !== 1'b1 && i < 20)
    begin
      @(negedge mclk);
      i++;
    end
    chk("word_valid", 27'h1, {26'h0, word_valid});
    chk("word", {f, p, d}, {word_is_data, word_pidx, word_data});
    word_ready = 1'b1;
    @(negedge mclk);
    word_ready = 1'b0;
  endtask : pop

  ////////////////////////////////////////////////////////////////////////
  task t_modes();
    lhp_mode_e e;
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 8; m++)
      begin
        setup(s[0], m[2:0]);
        e = !m[2] ? LHP_SERIAL : m[1:0] == 2'h0 ? LHP_PAR8 :
          m[1:0] == 2'h1 ? LHP_PAR16 : m[1:0] == 2'h2 ? LHP_PAR9 : LHP_PAR18;
        chk("bus_mode", {22'h0, e}, {22'h0, bus_mode});
        chk("style", {26'h0, s[0]}, {26'h0, sty});
        chk("serial", {26'h0, !m[2]}, {26'h0, ser});
      end
  endtask : t_modes

  task t_traffic(input logic s, input logic [1:0] w);
    int n;
    setup(s, {1'b1, w});
    host.write(1'b1, 1'b0, 18'h3ff5a);
    host.write(1'b1, 1'b1, 18'h3ffff);
    host.write(1'b1, 1'b1, 18'h2a5c3);
    host.write(1'b1, 1'b0, 18'h00011);
    host.write(1'b1, 1'b1, 18'h00077);
    pop(1'b0, 8'h00, 18'h0005a);
    pop(1'b1, 8'h00, mask(w));
    pop(1'b1, 8'h01, 18'h2a5c3 & mask(w));
    pop(1'b0, 8'h02, 18'h00011);
    pop(1'b1, 8'h00, 18'h00077);
    n = reads;
    read_ram = 1'b0;
    host.read(1'b1, v);
    chk("status", {9'h0, 18'h000c3}, {9'h0, v});
    chk("read_dc", 27'h1, {26'h0, read_dc});
    read_ram = 1'b1;
    host.read(1'b1, v);
    chk("ram", {9'h0, 18'h2a5c3 & mask(w)}, {9'h0, v});
    chk("read_req", 27'h2, 27'(reads - n));
    chk("oe", 27'h0, {26'h0, oe});
  endtask : t_traffic

  task t_refuse();
    setup(1'b0, 3'b111);
    host.write(1'b0, 1'b1, 18'h00011);
    chk("valid", 27'h0, {26'h0, word_valid});
    setup(1'b0, 3'b011);
    host.write(1'b1, 1'b1, 18'h00022);
    host.read(1'b1, v);
    chk("q", {9'h0, 18'h3ffdd}, {9'h0, v});
    chk("valid", 27'h0, {26'h0, word_valid});
    chk("oe", 27'h0, {26'h0, oe});
  endtask : t_refuse

  task t_fill();
    setup(1'b0, 3'b111);
    for (int i = 0; i < 33; i++)
      host.write(1'b1, 1'b1, i[17:0]);
    chk("wr_ready", 27'h0, {26'h0, wr_ready});
    chk("overflow", 27'h1, {26'h0, overflow});
    for (int i = 0; i < 32; i++)
      pop(1'b1, i[7:0], i[17:0]);
    chk("valid", 27'h0, {26'h0, word_valid});
    chk("overflow", 27'h1, {26'h0, overflow});
    setup(1'b0, 3'b111);
    chk("overflow", 27'h0, {26'h0, overflow});
  endtask : t_fill

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    hw_reset_n = 1'b1;
    strap = 1'b0;
    im = 3'b100;
    word_ready = 1'b0;
    read_ram = 1'b0;
    read_data = 18'h2a5c3;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    t_modes();
    for (int s = 0; s < 2; s++)
      for (int w = 0; w < 4; w++)
        t_traffic(s[0], w[1:0]);
    t_refuse();
    t_fill();
    summarize();
  end

  // Whole run needs about 7.4 us
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
